// ---- rtl/pom_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none

module pom_ctrl #(
   parameter int P_STRETCH_US = pom_pkg::T_STRETCH_US,
   parameter int P_NV_WRITE_US = pom_pkg::T_NV_WRITE_US,
   parameter int P_MGMT_START_US = pom_pkg::T_MGMT_START_US,
   parameter int P_WARMUP_US = pom_pkg::T_WARMUP_US
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   output logic irq_o,
   // Host connector pins
   input wire logic laser_disable_i,
   output logic laser_disable_pu_o,
   output logic tx_fault_o,
   output logic tx_fault_oe_o,
   output logic rx_los_o,
   output logic rx_los_oe_o,
   output logic mod_abs_o,
   output logic mod_abs_oe_o,
   input wire logic rate_select_zero_i,
   input wire logic rate_select_one_i,
   output logic rate_select_pd_o,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   // Serial engine side
   input wire logic stretch_req_i,
   input wire logic nv_write_end_i,
   input wire logic nv_done_i,
   input wire logic [pom_pkg::BURST_W-1:0] nv_bytes_i,
   input wire logic hp_enable_i,
   output logic mgmt_ready_o,
   output logic mgmt_nack_o,
   output logic nv_commit_o,
   // Optics side
   input wire logic laser_fault_i,
   input wire logic rx_signal_ok_i,
   output logic laser_on_o,
   output logic oper_o
);

   // Timer tick divider
   logic [7:0] div_q;
   logic tick;

   assign tick = (div_q == 8'(pom_pkg::TICK_CYC - 1));

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i || tick)
      begin
         div_q <= 8'h00;
      end
      else
      begin
         div_q <= div_q + 8'h01;
      end
   end

   // Bus address phase decode
   logic addr_take;
   logic wr_q;
   logic [7:0] waddr_q;
   logic [pom_pkg::CTRL_W-1:0] ctrl_q;
   logic [pom_pkg::EVT_W-1:0] evt_q;
   logic [pom_pkg::EVT_W-1:0] mask_q;
   logic [pom_pkg::EVT_W-1:0] evt_set;
   logic wr_ctrl;
   logic wr_evt;
   logic wr_mask;
   logic in_map;

   assign addr_take = hsel_i && hready_i && (htrans_i == pom_pkg::HTRANS_NONSEQ);
   assign in_map = (haddr_i[31:8] == 24'h000000);
   assign wr_ctrl = wr_q && (waddr_q == pom_pkg::OFS_CTRL);
   assign wr_evt = wr_q && (waddr_q == pom_pkg::OFS_EVT);
   assign wr_mask = wr_q && (waddr_q == pom_pkg::OFS_MASK);

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         wr_q <= 1'b0;
         waddr_q <= 8'h00;
      end
      else
      begin
         wr_q <= addr_take && hwrite_i && in_map;
         waddr_q <= haddr_i[7:0];
      end
   end

   // Timers
   logic stretch_exp;
   logic nv_exp;
   logic start_exp;
   logic warm_exp;
   logic warm_start;
   logic nv_busy_q;
   logic stretch_hold_q;
   pom_pkg::pom_state_t state_q;
   pom_pkg::pom_state_t state_d;

   pom_tick_timer u_stretch (
      .clk_i(core_clk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .start_i(!stretch_req_i),
      .run_i(stretch_req_i),
      .limit_i(pom_pkg::TMR_W'(P_STRETCH_US - 1)),
      .expired_o(stretch_exp)
   );

   pom_tick_timer u_nv (
      .clk_i(core_clk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .start_i(nv_write_end_i),
      .run_i(nv_busy_q),
      .limit_i(pom_pkg::TMR_W'(P_NV_WRITE_US - 1)),
      .expired_o(nv_exp)
   );

   pom_tick_timer u_start (
      .clk_i(core_clk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .start_i(1'b0),
      .run_i(1'b1),
      .limit_i(pom_pkg::TMR_W'(P_MGMT_START_US - 1)),
      .expired_o(start_exp)
   );

   pom_tick_timer u_warm (
      .clk_i(core_clk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .start_i(warm_start),
      .run_i(state_q == pom_pkg::ST_WARM),
      .limit_i(pom_pkg::TMR_W'(P_WARMUP_US - 1)),
      .expired_o(warm_exp)
   );

   // Clock stretch limiter
   logic stretch_cut;

   assign stretch_cut = stretch_req_i && stretch_exp;

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         stretch_hold_q <= 1'b0;
      end
      else
      begin
         stretch_hold_q <= stretch_req_i && !stretch_exp;
      end
   end

   // Nonvolatile commit tracking
   logic nv_late;
   logic [pom_pkg::BURST_W-1:0] nv_len;

   assign nv_late = nv_busy_q && nv_exp && !nv_done_i;
   assign nv_len = (nv_bytes_i > pom_pkg::BURST_W'(pom_pkg::NV_BURST_MAX)) ?
                   pom_pkg::BURST_W'(pom_pkg::NV_BURST_MAX) : nv_bytes_i;

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         nv_busy_q <= 1'b0;
      end
      else if (nv_write_end_i && (nv_len != '0))
      begin
         nv_busy_q <= 1'b1;
      end
      else if (nv_done_i || nv_exp)
      begin
         nv_busy_q <= 1'b0;
      end
   end

   // Disable pin: hold counter for fault reset
   logic dis_q;
   logic dis_fall;
   logic [pom_pkg::HOLD_W-1:0] hold_q;
   logic fault_clr;

   assign dis_fall = dis_q && !laser_disable_i;
   assign fault_clr = laser_disable_i && (hold_q == pom_pkg::HOLD_W'(pom_pkg::FAULT_RST_CYC - 1));

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         dis_q <= 1'b1;
         hold_q <= '0;
      end
      else
      begin
         dis_q <= laser_disable_i;
         if (!laser_disable_i)
         begin
            hold_q <= '0;
         end
         else if (hold_q != pom_pkg::HOLD_W'(pom_pkg::FAULT_RST_CYC))
         begin
            hold_q <= hold_q + 1'b1;
         end
      end
   end

   // Operating state machine
   logic fault_set;

   assign fault_set = laser_fault_i;
   assign warm_start = (dis_fall && (state_q == pom_pkg::ST_WARM))
                    || (hp_enable_i && (state_q == pom_pkg::ST_RUN))
                    || ((state_q == pom_pkg::ST_FAULT) && fault_clr && !fault_set);

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         pom_pkg::ST_WARM:
         begin
            if (fault_set)
            begin
               state_d = pom_pkg::ST_FAULT;
            end
            else if (warm_exp && !warm_start)
            begin
               state_d = pom_pkg::ST_RUN;
            end
         end
         pom_pkg::ST_RUN:
         begin
            if (fault_set)
            begin
               state_d = pom_pkg::ST_FAULT;
            end
            else if (hp_enable_i)
            begin
               state_d = pom_pkg::ST_WARM;
            end
         end
         pom_pkg::ST_FAULT:
         begin
            if (fault_clr && !fault_set)
            begin
               state_d = pom_pkg::ST_WARM;
            end
         end
         default:
         begin
            state_d = pom_pkg::ST_WARM;
         end
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         state_q <= pom_pkg::ST_WARM;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // Pin and side outputs
   logic laser_on_d;
   logic los_d;
   logic los_q;

   assign laser_on_d = (state_d == pom_pkg::ST_RUN) && !laser_disable_i
                    && !ctrl_q[pom_pkg::CTRL_SOFT_OFF];
   assign los_d = !rx_signal_ok_i;

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         laser_on_o <= 1'b0;
         oper_o <= 1'b0;
         tx_fault_oe_o <= 1'b0;
         los_q <= 1'b0;
         rx_los_oe_o <= 1'b0;
         scl_oe_o <= 1'b0;
         mgmt_ready_o <= 1'b0;
         mgmt_nack_o <= 1'b1;
         nv_commit_o <= 1'b0;
      end
      else
      begin
         laser_on_o <= laser_on_d;
         oper_o <= (state_d == pom_pkg::ST_RUN);
         tx_fault_oe_o <= (state_d == pom_pkg::ST_FAULT);
         los_q <= los_d;
         rx_los_oe_o <= !los_d;
         scl_oe_o <= stretch_req_i && !stretch_exp;
         mgmt_ready_o <= start_exp;
         mgmt_nack_o <= !start_exp || nv_busy_q || (nv_write_end_i && (nv_len != '0));
         nv_commit_o <= nv_write_end_i && (nv_len != '0);
      end
   end

   // Constant pin levels: low drive only, pulls enabled
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         tx_fault_o <= 1'b0;
         rx_los_o <= 1'b0;
         scl_o <= 1'b0;
         mod_abs_o <= 1'b0;
         mod_abs_oe_o <= 1'b1;
         laser_disable_pu_o <= 1'b1;
         rate_select_pd_o <= 1'b1;
      end
      else
      begin
         tx_fault_o <= 1'b0;
         rx_los_o <= 1'b0;
         scl_o <= 1'b0;
         mod_abs_o <= 1'b0;
         mod_abs_oe_o <= 1'b1;
         laser_disable_pu_o <= 1'b1;
         rate_select_pd_o <= 1'b1;
      end
   end

   // Events: set wins over write-one-to-clear
   assign evt_set[pom_pkg::EVT_FAULT] = (state_d == pom_pkg::ST_FAULT) && (state_q != pom_pkg::ST_FAULT);
   assign evt_set[pom_pkg::EVT_LOS] = (los_d != los_q);
   assign evt_set[pom_pkg::EVT_NV_LATE] = nv_late;
   assign evt_set[pom_pkg::EVT_STRETCH] = stretch_cut && stretch_hold_q;
   assign evt_set[pom_pkg::EVT_OPER] = (state_d == pom_pkg::ST_RUN) && (state_q != pom_pkg::ST_RUN);

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         ctrl_q <= pom_pkg::CTRL_RST;
         mask_q <= pom_pkg::MASK_RST;
         evt_q <= pom_pkg::EVT_RST;
         irq_o <= 1'b0;
      end
      else
      begin
         if (wr_ctrl)
         begin
            ctrl_q <= hwdata_i[pom_pkg::CTRL_W-1:0];
         end
         if (wr_mask)
         begin
            mask_q <= hwdata_i[pom_pkg::EVT_W-1:0];
         end
         evt_q <= evt_set | (evt_q & ~(wr_evt ? hwdata_i[pom_pkg::EVT_W-1:0] : '0));
         irq_o <= |(evt_q & mask_q);
      end
   end

   // Read data, captured in the address phase
   logic [31:0] rd_val;
   logic [31:0] state_word;

   assign state_word = {21'h000000, rate_select_one_i, rate_select_zero_i, scl_i, state_q,
                        nv_busy_q, start_exp, los_q, laser_on_o, tx_fault_oe_o};
   assign rd_val = !in_map ? 32'h00000000 :
                   (haddr_i[7:0] == pom_pkg::OFS_CTRL) ? {31'h00000000, ctrl_q} :
                   (haddr_i[7:0] == pom_pkg::OFS_STATE) ? state_word :
                   (haddr_i[7:0] == pom_pkg::OFS_EVT) ? {27'h0000000, evt_q} :
                   (haddr_i[7:0] == pom_pkg::OFS_MASK) ? {27'h0000000, mask_q} : 32'h00000000;

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         hrdata_o <= 32'h00000000;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end
      else
      begin
         hrdata_o <= (addr_take && !hwrite_i) ? rd_val : 32'h00000000;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ---- rtl/pom_pkg.sv ----
package pom_pkg;

   // Core clock
   localparam int CLK_MHZ = 200;
   localparam int TICK_CYC = CLK_MHZ;

   // Timing limits in microseconds, one timer tick per microsecond
   localparam int T_STRETCH_US = 500;
   localparam int T_NV_WRITE_US = 40000;
   localparam int T_MGMT_START_US = 300000;
   localparam int T_WARMUP_US = 90000000;
   localparam int T_FAULT_RST_US = 10;
   localparam int FAULT_RST_CYC = T_FAULT_RST_US * CLK_MHZ;
   localparam int NV_BURST_MAX = 8;

   localparam int TMR_W = 27;
   localparam int HOLD_W = 12;
   localparam int BURST_W = 4;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATE = 8'h04;
   localparam logic [7:0] OFS_EVT = 8'h08;
   localparam logic [7:0] OFS_MASK = 8'h0c;

   // Control register fields
   localparam int CTRL_SOFT_OFF = 0;
   localparam int CTRL_W = 1;
   localparam logic [CTRL_W-1:0] CTRL_RST = 1'h0;

   // Event register fields, mask shares the layout
   localparam int EVT_FAULT = 0;
   localparam int EVT_LOS = 1;
   localparam int EVT_NV_LATE = 2;
   localparam int EVT_STRETCH = 3;
   localparam int EVT_OPER = 4;
   localparam int EVT_W = 5;
   localparam logic [EVT_W-1:0] EVT_RST = 5'h00;
   localparam logic [EVT_W-1:0] MASK_RST = 5'h00;

   // Operating state
   typedef enum logic [2:0] {
      ST_WARM = 3'b001,
      ST_RUN = 3'b010,
      ST_FAULT = 3'b100
   } pom_state_t;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// ---- rtl/pom_tick_timer.sv ----
`timescale 1ns/1ps
`default_nettype none

module pom_tick_timer (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   input wire logic tick_i,
   input wire logic start_i,
   input wire logic run_i,
   input wire logic [pom_pkg::TMR_W-1:0] limit_i,
   // Result
   output logic expired_o
);

   logic [pom_pkg::TMR_W-1:0] count_q;

   assign expired_o = (count_q >= limit_i);

   always_ff @(posedge clk_i)
   begin
      if (rst_i || start_i)
      begin
         count_q <= '0;
      end
      else if (run_i && tick_i && !expired_o)
      begin
         count_q <= count_q + 1'b1;
      end
   end

endmodule

`default_nettype wire

// ---- bench/pom_ctrl_chk.sv ----
`timescale 1ns/1ps
`default_nettype none

module pom_ctrl_chk #(
   parameter int P_STRETCH_US = 500,
   parameter int P_NV_WRITE_US = 40000,
   parameter int P_MGMT_START_US = 300000
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Bus answer
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   // Host connector pins
   input wire logic laser_disable_i,
   input wire logic laser_disable_pu_o,
   input wire logic tx_fault_o,
   input wire logic tx_fault_oe_o,
   input wire logic rx_los_o,
   input wire logic rx_los_oe_o,
   input wire logic mod_abs_o,
   input wire logic mod_abs_oe_o,
   input wire logic rate_select_pd_o,
   input wire logic scl_o,
   input wire logic scl_oe_o,
   // Serial engine side
   input wire logic nv_write_end_i,
   input wire logic [pom_pkg::BURST_W-1:0] nv_bytes_i,
   input wire logic mgmt_ready_o,
   input wire logic mgmt_nack_o,
   input wire logic nv_commit_o,
   // Optics side
   input wire logic laser_fault_i,
   input wire logic rx_signal_ok_i,
   input wire logic laser_on_o
);
   localparam int STR_LIM = P_STRETCH_US * pom_pkg::TICK_CYC;
   localparam int NV_LIM = P_NV_WRITE_US * pom_pkg::TICK_CYC + 2;
   localparam int BOOT_LIM = P_MGMT_START_US * pom_pkg::TICK_CYC + 2;
   int unsigned str_q, nv_q, boot_q, hold_q;

   // Cycle counters for the long limits
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         str_q <= 0;
         nv_q <= 0;
         boot_q <= 0;
         hold_q <= 0;
      end
      else
      begin
         str_q <= scl_oe_o ? str_q + 1 : 0;
         nv_q <= (mgmt_nack_o && mgmt_ready_o) ? nv_q + 1 : 0;
         boot_q <= (boot_q < BOOT_LIM) ? boot_q + 1 : boot_q;
         hold_q <= laser_disable_i ? hold_q + 1 : 0;
      end
   end

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_nv_start;
      nv_write_end_i && nv_bytes_i != 4'h0;
   endsequence
   sequence s_commit_busy;
      nv_commit_o && mgmt_nack_o;
   endsequence

   a_bus_okay: assert property (hreadyout_o && !hresp_o)
      else $error("bus answer not ready and okay");
   a_laser_off: assert property (laser_disable_i |=> !laser_on_o)
      else $error("laser still on after disable");
   a_fault_fast: assert property (laser_fault_i |=> tx_fault_oe_o)
      else $error("fault output late");
   a_los_follow: assert property (1'b1 |=> rx_los_oe_o == $past(rx_signal_ok_i))
      else $error("loss of signal output late");
   a_pins_drain: assert property (!tx_fault_o && !rx_los_o && !scl_o)
      else $error("open drain pin driven high");
   a_strap_pulls: assert property (mod_abs_oe_o && !mod_abs_o && laser_disable_pu_o && rate_select_pd_o)
      else $error("strap or pull not in place");
   a_stretch_limit: assert property (str_q <= STR_LIM)
      else $error("clock held low too long");
   a_commit_busy: assert property (s_nv_start |=> s_commit_busy)
      else $error("commit not started or not busy");
   a_nv_limit: assert property (nv_q <= NV_LIM)
      else $error("commit busy too long");
   a_mgmt_start: assert property (boot_q >= BOOT_LIM |-> mgmt_ready_o)
      else $error("serial interface not ready in time");
   a_fault_clear: assert property (hold_q == pom_pkg::FAULT_RST_CYC && !laser_fault_i |-> ##[1:3] !tx_fault_oe_o)
      else $error("fault not cleared by long disable");
   a_fault_kept: assert property ($fell(tx_fault_oe_o) |-> hold_q >= pom_pkg::FAULT_RST_CYC - 2)
      else $error("fault cleared by short disable");
endmodule

bind pom_ctrl pom_ctrl_chk #(.P_STRETCH_US(P_STRETCH_US), .P_NV_WRITE_US(P_NV_WRITE_US),
   .P_MGMT_START_US(P_MGMT_START_US)) chk_u (.*);

`default_nettype wire

// ---- bench/pom_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module pom_host_model (
   // Host drive of the disable pin
   input wire logic drv_en_i,
   input wire logic drv_val_i,
   // Module pin controls
   input wire logic pu_i,
   input wire logic tx_fault_oe_i,
   input wire logic rx_los_oe_i,
   input wire logic mod_abs_oe_i,
   // Resolved pin levels
   output logic dis_pin_o,
   output logic tx_fault_pin_o,
   output logic rx_los_pin_o,
   output logic mod_abs_pin_o
);
   // Undriven pin floats to the pull-up, else away from the last drive
   assign dis_pin_o = drv_en_i ? drv_val_i : (pu_i ? 1'b1 : !drv_val_i);
   // Host pull-ups give the released high level
   assign tx_fault_pin_o = !tx_fault_oe_i;
   assign rx_los_pin_o = !rx_los_oe_i;
   assign mod_abs_pin_o = !mod_abs_oe_i;
endmodule

`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   localparam int STR = 5;
   localparam int NVW = 20;
   localparam int TK = pom_pkg::TICK_CYC;
   localparam int FR = pom_pkg::FAULT_RST_CYC;
   logic core_clk_i = 1'b0, rst_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0;
   logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, rd_v;
   logic [1:0] htrans_i = 2'h0;
   logic [2:0] hsize_i = 3'h2;
   logic rate_select_zero_i = 1'b0, rate_select_one_i = 1'b0, scl_i = 1'b0, stretch_req_i = 1'b0;
   logic nv_write_end_i = 1'b0, nv_done_i = 1'b0, hp_enable_i = 1'b0, laser_fault_i = 1'b0;
   logic [3:0] nv_bytes_i = 4'h0;
   logic rx_signal_ok_i = 1'b1, dis_en = 1'b1, dis_val = 1'b0, laser_disable_i;
   logic hreadyout_o, hresp_o, irq_o, laser_disable_pu_o, tx_fault_o, tx_fault_oe_o, rx_los_o, rx_los_oe_o;
   logic mod_abs_o, mod_abs_oe_o, rate_select_pd_o, scl_o, scl_oe_o, mgmt_ready_o, mgmt_nack_o;
   logic nv_commit_o, laser_on_o, oper_o, tf_pin, los_pin, abs_pin;
   logic [31:0] hrdata_o;
   wire hready_i = hreadyout_o;
   int num_errors = 0;
   int tests_run = 0;

   always #2.5 core_clk_i = ~core_clk_i;

   pom_ctrl #(.P_STRETCH_US(STR), .P_NV_WRITE_US(NVW), .P_MGMT_START_US(10), .P_WARMUP_US(10)) dut_u (.*);

   pom_host_model host_u (.drv_en_i(dis_en), .drv_val_i(dis_val), .pu_i(laser_disable_pu_o),
      .tx_fault_oe_i(tx_fault_oe_o), .rx_los_oe_i(rx_los_oe_o), .mod_abs_oe_i(mod_abs_oe_o),
      .dis_pin_o(laser_disable_i), .tx_fault_pin_o(tf_pin), .rx_los_pin_o(los_pin), .mod_abs_pin_o(abs_pin));

   task automatic give_verdict;
      if (num_errors == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask

   // One single AHB-Lite transfer
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      hsel_i <= 1'b1;
      haddr_i <= a;
      hwrite_i <= wr;
      htrans_i <= pom_pkg::HTRANS_NONSEQ;
      do @(posedge core_clk_i); while (hready_i !== 1'b1);
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(posedge core_clk_i); while (hready_i !== 1'b1);
      rd_v = hrdata_o;
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(rd_v & m, e);
   endtask

   // Commit pulse stands one cycle, so look just after its launching edge
   task automatic nv_end(input logic [3:0] n, input logic c);
      nv_bytes_i <= n;
      nv_write_end_i <= 1'b1;
      tick(1);
      nv_write_end_i <= 1'b0;
      #1;
      check({nv_commit_o, mgmt_nack_o}, {c, c});
      tick(1);
   endtask

   task automatic wait_oper;
      for (int i = 0; i < 4000 && oper_o !== 1'b1; i++) @(posedge core_clk_i);
   endtask

   initial
   begin
      #200000;
      num_errors++;
      give_verdict;
   end

   initial
   begin
      tick(8);
      rst_i <= 1'b0;
      rd(32'h04, 32'hffffffff, 32'h20);
      check(mgmt_nack_o, 1'b1);
      check(abs_pin, 1'b0);
      for (int a = 0; a < 'h14; a += 4)
         if (a != 4)
            rd(a, 32'hffffffff, 32'h0);
      rd(32'h100, 32'hffffffff, 32'h0);
      for (int i = 0; i < 3000 && mgmt_ready_o !== 1'b1; i++) @(posedge core_clk_i);
      check(mgmt_ready_o, 1'b1);
      wait_oper;
      tick(2);
      check(laser_on_o, 1'b1);
      rate_select_zero_i <= 1'b1;
      scl_i <= 1'b1;
      bus(1'b1, 32'h04, 32'hffffffff);
      rd(32'h04, 32'hffffffff, 32'h34a);
      rd(32'h08, 32'h10, 32'h10);
      // Interrupt unmasked, raised and cleared
      bus(1'b1, 32'h0c, 32'h10);
      tick(3);
      check(irq_o, 1'b1);
      bus(1'b1, 32'h08, 32'h1f);
      tick(3);
      check(irq_o, 1'b0);
      // Disable released to the pull-up, then driven low
      dis_en <= 1'b0;
      tick(3);
      check(laser_on_o, 1'b0);
      dis_en <= 1'b1;
      tick(3);
      check(laser_on_o, 1'b1);
      // Fault latch, short hold, full hold
      laser_fault_i <= 1'b1;
      tick(1);
      laser_fault_i <= 1'b0;
      tick(3);
      check({tf_pin, oper_o}, 2'b00);
      rd(32'h08, 32'h1, 32'h1);
      dis_val <= 1'b1;
      tick(FR / 2);
      dis_val <= 1'b0;
      tick(3);
      check(tf_pin, 1'b0);
      dis_val <= 1'b1;
      tick(FR + 5);
      dis_val <= 1'b0;
      check(tf_pin, 1'b1);
      wait_oper;
      check(oper_o, 1'b1);
      // Loss and return of the optical signal
      rx_signal_ok_i <= 1'b0;
      tick(3);
      check(los_pin, 1'b1);
      rx_signal_ok_i <= 1'b1;
      tick(3);
      check(los_pin, 1'b0);
      rd(32'h08, 32'h2, 32'h2);
      // Clock stretch cut at its limit
      stretch_req_i <= 1'b1;
      tick(3);
      check(scl_oe_o, 1'b1);
      tick(STR * TK);
      check(scl_oe_o, 1'b0);
      stretch_req_i <= 1'b0;
      rd(32'h08, 32'h8, 32'h8);
      // Commit answered promptly, then never, then an empty write
      nv_end(4'h8, 1'b1);
      check(mgmt_nack_o, 1'b1);
      tick(50);
      nv_done_i <= 1'b1;
      tick(1);
      nv_done_i <= 1'b0;
      tick(3);
      check(mgmt_nack_o, 1'b0);
      nv_end(4'h8, 1'b1);
      tick(NVW * TK);
      check(mgmt_nack_o, 1'b0);
      rd(32'h08, 32'h4, 32'h4);
      nv_end(4'h0, 1'b0);
      check(nv_commit_o, 1'b0);
      // Higher power enable restarts warm-up
      hp_enable_i <= 1'b1;
      tick(1);
      hp_enable_i <= 1'b0;
      tick(3);
      check(oper_o, 1'b0);
      wait_oper;
      check(oper_o, 1'b1);
      give_verdict;
   end
endmodule

`default_nettype wire
